// ### dv/bgf_phy.sv
`timescale 1ns/100ps
module bgf_phy (
  input  wire       mclk,
  input  wire [3:0] lat,
  input  wire       link_tx_valid,
  output reg        link_tx_done = 1'b0,
  output reg        link_tx_ok = 1'b0
);
  integer n = 0;
  // answers lat+1 cycles after the offer, always successfully
  always @(posedge mclk) begin
    n <= (link_tx_valid && !link_tx_done) ? n + 1 : 0;
    link_tx_done <= link_tx_valid && !link_tx_done && n == lat;
    link_tx_ok <= link_tx_valid && !link_tx_done && n == lat;
  end
endmodule // bgf_phy

// ### dv/bgf_port_tb_top.sv
`timescale 1ns/100ps
module bgf_port_tb_top;
  logic        mclk, init_done, flt_refused, host_tx_busy, host_tx_done;
  logic        host_tx_ok, host_tx_refused, host_rx_valid, host_rx_kind;
  logic        host_rx_drop, link_tx_valid, link_tx_kind, link_ack;
  logic        link_tx_done, link_tx_ok, host_tx_req = 1'b0;
  logic        rst = 1'b1, flt_wr = 1'b0, flt_valid = 1'b0;
  logic        host_tx_kind = 1'b0, link_rx_valid = 1'b0, link_rx_kind = 1'b0;
  logic [1:0]  mode_sel = 2'h1;
  logic [2:0]  flt_num = 3'h0, host_rx_filter;
  logic [3:0]  lat = 4'h0;
  logic [5:0]  flt_entry = 6'h00;
  logic [7:0]  host_tx_data = 8'h00, link_rx_data = 8'h00;
  logic [7:0]  host_rx_data, link_tx_data;
  logic [15:0] flt_gaddr = 16'h0000, host_tx_gaddr = 16'h0000;
  logic [15:0] link_rx_gaddr = 16'h0000, host_rx_gaddr, link_tx_gaddr;
  logic [31:0] seed = 32'h9F1B;
  int          tbl[256];
  int          num_errors = 0;
  int          total_checks = 0;

  bgf_port i_dut (.*);
  bgf_phy  i_phy (.*);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (e !== g) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
    end
  endtask

  task load(input logic [2:0] n, input logic [5:0] e, input logic [15:0] a,
            input logic v);
    logic ok;
    ok = init_done && mode_sel != 2'h2 && (mode_sel == 2'h1 ? e < 32 : n < 4);
    {flt_num, flt_entry, flt_gaddr, flt_valid, flt_wr} <= {n, e, a, v, 1'b1};
    @(posedge mclk);
    flt_wr <= 1'b0;
    @(posedge mclk);
    chk("flt_refused", !ok, flt_refused);
    if (ok)
      tbl[mode_sel == 2'h1 ? {n, e[4:0]} : {n[1:0], e}] = v ? a : -1;
  endtask

  task send_tx(input logic k, input logic [3:0] l);
    logic [23:0] v;
    logic ok;
    v = 24'(rnd());
    ok = init_done && mode_sel != 2'h2;
    lat <= l;
    {host_tx_kind, host_tx_gaddr, host_tx_data, host_tx_req} <= {k, v, 1'b1};
    @(posedge mclk);
    host_tx_req <= 1'b0;
    for (int i = 0; i < 40 && host_tx_done !== 1'b1; i++) begin
      @(posedge mclk);
      if (link_tx_valid === 1'b1 && link_tx_done === 1'b1)
        chk("link_tx", {k, v},
            {link_tx_kind, link_tx_gaddr, link_tx_data});
    end
    chk("tx_end", {1'b1, ok, !ok},
        {host_tx_done, host_tx_ok, host_tx_refused});
    if (host_tx_done !== 1'b1)
      stop_test();
  endtask

  task recv(input logic k, input logic [15:0] a, input logic dup = 1'b0);
    logic [7:0] d;
    logic seen;
    int hit;
    int drops;
    d = 8'(rnd());
    seen = 1'b0;
    hit = -1;
    drops = 0;
    for (int i = 0; i < 256 && hit < 0; i++)
      if (tbl[i] == a)
        hit = i;
    if (mode_sel == 2'h2)
      hit = 0;
    {link_rx_kind, link_rx_gaddr, link_rx_data} <= {k, a, d};
    link_rx_valid <= 1'b1;
    @(posedge mclk);
    if (dup)
      @(posedge mclk);
    {link_rx_gaddr, link_rx_data, link_rx_valid} <= {~a, ~d, 1'b0};
    for (int i = 0; i < 270; i++) begin
      @(posedge mclk);
      if (host_rx_drop === 1'b1)
        drops++;
      if (host_rx_valid === 1'b1 && !seen) begin
        seen = 1'b1;
        chk("rx", {k, a, d, 3'(hit >> (mode_sel == 2'h1 ? 5 : 6)),
            mode_sel != 2'h2}, {host_rx_kind, host_rx_gaddr, host_rx_data,
            host_rx_filter, link_ack});
      end
    end
    chk("rx_seen", hit >= 0, seen);
    chk("rx_drop", dup && mode_sel != 2'h2, drops);
  endtask

  initial begin
    foreach (tbl[i]) tbl[i] = -1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    load(3'h0, 6'h00, 16'h0001, 1'b1);
    send_tx(1'b0, 4'h0);
    for (int i = 0; i < 300 && init_done !== 1'b1; i++)
      @(posedge mclk);
    chk("init_done", 1, init_done);
    if (init_done !== 1'b1)
      stop_test();
    $display("test reset done");
    load(3'h7, 6'h1F, 16'h1234, 1'b1);
    load(3'h2, 6'h05, 16'h1234, 1'b1);
    load(3'h1, 6'h20, 16'h5678, 1'b1);
    recv(1'b1, 16'h1234);
    load(3'h2, 6'h05, 16'h1234, 1'b0);
    recv(1'b0, 16'h1234);
    recv(1'b0, 16'h5678);
    mode_sel <= 2'h0;
    @(posedge mclk);
    load(3'h4, 6'h00, 16'h9ABC, 1'b1);
    load(3'h3, 6'h3F, 16'h9ABC, 1'b1);
    recv(1'b1, 16'h9ABC, 1'b1);
    mode_sel <= 2'h3;
    @(posedge mclk);
    recv(1'b0, 16'h9ABC);
    $display("test filter done");
    for (int i = 0; i < 4; i++)
      send_tx(i[0], 4'(rnd()));
    mode_sel <= 2'h2;
    @(posedge mclk);
    recv(1'b0, 16'(rnd()));
    send_tx(1'b1, 4'h0);
    $display("test monitor done");
    stop_test();
  end
endmodule // bgf_port_tb_top

// ### dv/bgf_props.sv
`timescale 1ns/100ps
module bgf_props (
  input wire       mclk,
  input wire       rst,
  input wire [1:0] mode_sel,
  input wire       init_done,
  input wire       flt_wr,
  input wire       flt_refused,
  input wire       host_tx_req,
  input wire       host_tx_busy,
  input wire       host_tx_done,
  input wire       host_tx_ok,
  input wire       host_tx_refused,
  input wire       host_rx_valid,
  input wire       link_tx_valid,
  input wire       link_tx_done,
  input wire       link_tx_ok,
  input wire       link_rx_valid,
  input wire       link_ack
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_mon_no_ack: assert property (
    $past(mode_sel) == 2'h2 |-> !link_ack) else $error("ack in monitor");
  a_mon_fwd: assert property (
    mode_sel == 2'h2 && link_rx_valid |=> host_rx_valid) else $error("lost");
  a_hit_ack: assert property (
    host_rx_valid |-> link_ack == ($past(mode_sel) != 2'h2))
    else $error("ack mismatch");
  a_tx_launch: assert property (
    host_tx_req && !host_tx_busy && init_done && mode_sel != 2'h2
    |=> link_tx_valid && host_tx_busy) else $error("no launch");
  a_tx_end: assert property (
    link_tx_valid && link_tx_done |=> host_tx_done && !link_tx_valid
    && host_tx_ok == $past(link_tx_ok)) else $error("bad finish");
  a_tx_refuse: assert property (
    host_tx_req && !host_tx_busy && (!init_done || mode_sel == 2'h2)
    |=> host_tx_done && host_tx_refused && !host_tx_ok)
    else $error("not refused");
  a_done_cause: assert property (
    host_tx_done |-> $past(host_tx_busy) || $past(host_tx_req))
    else $error("stray done");
  a_early_flt: assert property (
    flt_wr && !init_done |=> flt_refused) else $error("early load");
endmodule // bgf_props
bind bgf_port bgf_props i_props (.*);

// ### rtl/bgf_filter_mem.v
`timescale 1ns/100ps
module bgf_filter_mem #(
  parameter W     = 17,
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  input  wire          mclk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [W-1:0]  wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [W-1:0]  rd_data
);

  reg [W-1:0] mem [0:DEPTH-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // bgf_filter_mem

// ### rtl/bgf_port.v
// Notes on behaviour
// - mode four: four filters of sixty-four group entries, legacy layout
// - mode eight: eight filters of thirty-two group entries
// - monitor mode: every group telegram goes to host, never acknowledged
// - monitor mode: no telegram is ever transmitted on the bus
// - one host item per telegram; host waits for host_tx_done, success or not, before next
// - outgoing kinds are only group write and group read request
// - filtering modes: only filter hits reach host and get acknowledged
// - never more than eight filters in any mode
// - loaded entries take effect right after initialisation, no enable
// - matching uses group address only, data type ignored
`timescale 1ns/100ps
`include "bgf_regs.vh"
module bgf_port #(
  parameter DW = 8
) (
  input  wire          mclk,
  input  wire          rst,
  input  wire [1:0]    mode_sel,
  input  wire          flt_wr,
  input  wire [2:0]    flt_num,
  input  wire [5:0]    flt_entry,
  input  wire [15:0]   flt_gaddr,
  input  wire          flt_valid,
  output reg           init_done,
  output reg           flt_refused,
  input  wire          host_tx_req,
  input  wire          host_tx_kind,
  input  wire [15:0]   host_tx_gaddr,
  input  wire [DW-1:0] host_tx_data,
  output reg           host_tx_busy,
  output reg           host_tx_done,
  output reg           host_tx_ok,
  output reg           host_tx_refused,
  output reg           host_rx_valid,
  output reg           host_rx_kind,
  output reg  [15:0]   host_rx_gaddr,
  output reg  [DW-1:0] host_rx_data,
  output reg  [2:0]    host_rx_filter,
  output reg           host_rx_drop,
  output reg           link_tx_valid,
  output reg           link_tx_kind,
  output reg  [15:0]   link_tx_gaddr,
  output reg  [DW-1:0] link_tx_data,
  input  wire          link_tx_done,
  input  wire          link_tx_ok,
  input  wire          link_rx_valid,
  input  wire          link_rx_kind,
  input  wire [15:0]   link_rx_gaddr,
  input  wire [DW-1:0] link_rx_data,
  output reg           link_ack
);

  // table slot of a filter entry in the current layout
  function [7:0] bgf_index;
    input [1:0] mode;
    input [2:0] num;
    input [5:0] ent;
    begin
      if (mode == `BGF_MODE_EIGHT) begin
        bgf_index = {num, ent[4:0]};
      end else begin
        bgf_index = {num[1:0], ent};
      end
    end
  endfunction

  // filter number that owns a table slot
  function [2:0] bgf_filter_of;
    input [1:0] mode;
    input [7:0] idx;
    begin
      if (mode == `BGF_MODE_EIGHT) begin
        bgf_filter_of = idx[7:5];
      end else begin
        bgf_filter_of = {1'b0, idx[7:6]};
      end
    end
  endfunction

  // receive states
  localparam [1:0] ST_RX_IDLE = `BGF_RX_IDLE;
  localparam [1:0] ST_RX_SCAN = `BGF_RX_SCAN;

  // transmit states
  localparam [0:0] ST_TX_IDLE = `BGF_TX_IDLE;
  localparam [0:0] ST_TX_WAIT = `BGF_TX_WAIT;

  wire                  mon_mode;
  wire                  flt_ok;
  reg                   mem_we;
  reg  [7:0]            mem_wa;
  reg  [`BGF_ENT_W-1:0] mem_wd;
  wire [`BGF_ENT_W-1:0] mem_rd;

  reg  [8:0]            clr_idx_q;
  reg  [1:0]            rx_st_q;
  reg  [8:0]            sidx_q;
  reg                   pvld_q;
  reg  [7:0]            pidx_q;
  reg                   rx_kind_q;
  reg  [15:0]           rx_gaddr_q;
  reg  [DW-1:0]         rx_data_q;
  reg                   tx_st_q;

  // value 3 on mode_sel keeps the four-filter layout
  assign mon_mode = (mode_sel == `BGF_MODE_MON);

  // only as many filters and entries as the layout holds
  assign flt_ok = (mode_sel == `BGF_MODE_EIGHT) ?
                  ({1'b0, flt_entry} < `BGF_ENT_EIGHT) :
                  (flt_num < `BGF_FLT_FOUR);

  // write port: table clear during init, host loads after
  always @* begin
    mem_we = 1'b0;
    mem_wa = clr_idx_q[7:0];
    mem_wd = `BGF_ENT_RST;
    // the clear owns the write port until it is through
    if (!init_done) begin
      mem_we = 1'b1;
    end else if (flt_wr && !mon_mode && flt_ok) begin
      mem_we = 1'b1;
      mem_wa = bgf_index(mode_sel, flt_num, flt_entry);
      mem_wd = {flt_valid, flt_gaddr};
    end
  end

  bgf_filter_mem #(
    .W     (`BGF_ENT_W),
    .DEPTH (`BGF_TBL_DEPTH),
    .AW    (`BGF_IDX_W)
  ) u_group_address_filter_table (
    .mclk    (mclk),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (mem_wd),
    .rd_addr (sidx_q[7:0]),
    .rd_data (mem_rd)
  );

  // table clear after reset, then filtering is live at once
  always @(posedge mclk) begin
    if (rst) begin
      clr_idx_q <= 9'h000;
      init_done <= 1'b0;
    end else if (!init_done) begin
      clr_idx_q <= clr_idx_q + 9'h001;
      if (clr_idx_q[7:0] == `BGF_IDX_LAST) begin
        init_done <= 1'b1;
      end
    end
  end

  // filter writes that are not taken
  always @(posedge mclk) begin
    if (rst) begin
      flt_refused <= 1'b0;
    end else begin
      flt_refused <= flt_wr && (!init_done || mon_mode || !flt_ok);
    end
  end

  // receive path: monitor pass-through or table scan
  always @(posedge mclk) begin
    if (rst) begin
      rx_st_q        <= `BGF_RX_IDLE;
      sidx_q         <= 9'h000;
      pvld_q         <= 1'b0;
      pidx_q         <= 8'h00;
      rx_kind_q      <= `BGF_KIND_WRITE;
      rx_gaddr_q     <= 16'h0000;
      rx_data_q      <= {DW{1'b0}};
      host_rx_valid  <= 1'b0;
      host_rx_kind   <= `BGF_KIND_WRITE;
      host_rx_gaddr  <= 16'h0000;
      host_rx_data   <= {DW{1'b0}};
      host_rx_filter <= 3'h0;
      host_rx_drop   <= 1'b0;
      link_ack       <= 1'b0;
    end else begin
      host_rx_valid <= 1'b0;
      host_rx_drop  <= 1'b0;
      link_ack      <= 1'b0;
      pvld_q        <= 1'b0;
      case (rx_st_q)
        ST_RX_IDLE: begin
          if (link_rx_valid && mon_mode) begin
            host_rx_valid  <= 1'b1;
            host_rx_kind   <= link_rx_kind;
            host_rx_gaddr  <= link_rx_gaddr;
            host_rx_data   <= link_rx_data;
            host_rx_filter <= 3'h0;
          end else if (link_rx_valid && init_done) begin
            rx_kind_q  <= link_rx_kind;
            rx_gaddr_q <= link_rx_gaddr;
            rx_data_q  <= link_rx_data;
            sidx_q     <= 9'h000;
            rx_st_q    <= ST_RX_SCAN;
          end
        end
        ST_RX_SCAN: begin
          if (!sidx_q[8]) begin
            sidx_q <= sidx_q + 9'h001;
            pvld_q <= 1'b1;
            pidx_q <= sidx_q[7:0];
          end
          // outside monitor mode a telegram during a scan is lost; host sees the drop
          if (link_rx_valid && !mon_mode) begin
            host_rx_drop <= 1'b1;
          end
          if (mon_mode) begin
            // scan abandoned; a telegram arriving now still reaches host
            rx_st_q <= ST_RX_IDLE;
            sidx_q  <= 9'h000;
            if (link_rx_valid) begin
              host_rx_valid  <= 1'b1;
              host_rx_kind   <= link_rx_kind;
              host_rx_gaddr  <= link_rx_gaddr;
              host_rx_data   <= link_rx_data;
              host_rx_filter <= 3'h0;
            end
          end else if (pvld_q && mem_rd[`BGF_ENT_VLD] &&
                       mem_rd[15:0] == rx_gaddr_q) begin
            host_rx_valid  <= 1'b1;
            link_ack       <= 1'b1;
            host_rx_kind   <= rx_kind_q;
            host_rx_gaddr  <= rx_gaddr_q;
            host_rx_data   <= rx_data_q;
            host_rx_filter <= bgf_filter_of(mode_sel, pidx_q);
            rx_st_q        <= ST_RX_IDLE;
            sidx_q         <= 9'h000;
          end else if (pvld_q && pidx_q == `BGF_IDX_LAST) begin
            rx_st_q <= ST_RX_IDLE;
            sidx_q  <= 9'h000;
          end
        end
        default: begin
          rx_st_q <= ST_RX_IDLE;
        end
      endcase
    end
  end

  // transmit path: one telegram in flight at a time
  always @(posedge mclk) begin
    if (rst) begin
      tx_st_q         <= `BGF_TX_IDLE;
      host_tx_busy    <= 1'b0;
      host_tx_done    <= 1'b0;
      host_tx_ok      <= 1'b0;
      host_tx_refused <= 1'b0;
      link_tx_valid   <= 1'b0;
      link_tx_kind    <= `BGF_KIND_WRITE;
      link_tx_gaddr   <= 16'h0000;
      link_tx_data    <= {DW{1'b0}};
    end else begin
      host_tx_done    <= 1'b0;
      host_tx_refused <= 1'b0;
      case (tx_st_q)
        ST_TX_IDLE: begin
          if (host_tx_req && (mon_mode || !init_done)) begin
            host_tx_refused <= 1'b1;
            host_tx_done    <= 1'b1;
            host_tx_ok      <= 1'b0;
          end else if (host_tx_req) begin
            link_tx_valid <= 1'b1;
            link_tx_kind  <= host_tx_kind;
            link_tx_gaddr <= host_tx_gaddr;
            link_tx_data  <= host_tx_data;
            host_tx_busy  <= 1'b1;
            host_tx_ok    <= 1'b0;
            tx_st_q       <= ST_TX_WAIT;
          end
        end
        ST_TX_WAIT: begin
          // requests while waiting are not looked at
          if (mon_mode) begin
            link_tx_valid   <= 1'b0;
            host_tx_busy    <= 1'b0;
            host_tx_done    <= 1'b1;
            host_tx_ok      <= 1'b0;
            host_tx_refused <= 1'b1;
            tx_st_q         <= ST_TX_IDLE;
          end else if (link_tx_done) begin
            link_tx_valid <= 1'b0;
            host_tx_busy  <= 1'b0;
            host_tx_done  <= 1'b1;
            host_tx_ok    <= link_tx_ok;
            tx_st_q       <= ST_TX_IDLE;
          end
        end
        default: begin
          tx_st_q <= ST_TX_IDLE;
        end
      endcase
    end
  end

endmodule // bgf_port

// ### rtl/bgf_regs.vh
`ifndef BGF_REGS_VH
`define BGF_REGS_VH

// operating modes on mode_sel
`define BGF_MODE_FOUR    2'h0
`define BGF_MODE_EIGHT   2'h1
`define BGF_MODE_MON     2'h2

// outgoing and incoming telegram kinds
`define BGF_KIND_WRITE   1'b0
`define BGF_KIND_READ    1'b1

// filter table geometry
`define BGF_TBL_DEPTH    256
`define BGF_IDX_W        8
`define BGF_IDX_LAST     8'hFF
`define BGF_FLT_FOUR     3'h4
`define BGF_ENT_FOUR     7'h40
`define BGF_ENT_EIGHT    7'h20

// table entry layout: {valid, group address}
`define BGF_ENT_VLD      16
`define BGF_ENT_W        17
`define BGF_ENT_RST      17'h00000

// receive and transmit states
`define BGF_RX_IDLE      2'h0
`define BGF_RX_SCAN      2'h1
`define BGF_TX_IDLE      1'b0
`define BGF_TX_WAIT      1'b1

`endif
